//--- src/gtimu_unit.sv
// Top: timer trigger, timeout and mask registers, interrupt status
`timescale 1ns/100ps
module gtimu_unit (
  input  wire logic                         sys_clk_in,
  input  wire logic                         reset_in,
  input  wire logic [gtimu_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [gtimu_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                         reg_write_in,
  input  wire logic                         reg_read_in,
  output logic      [gtimu_pkg::DATA_W-1:0] reg_rdata_out,
  input  wire logic                         cmd_set_default_in,
  input  wire logic                         cmd_start_gpt_in,
  input  wire logic                         rx_start_in,
  input  wire logic                         rx_end_in,
  input  wire logic                         tx_end_in,
  input  wire logic                         nfc_mode_in,
  input  wire logic [7:2]                   main_event_in,
  input  wire logic [7:0]                   timer_event_in,
  input  wire logic [7:0]                   error_event_in,
  output logic                              irq_out,
  output logic                              field_off_out,
  output logic                              gpt_running_out
);
  import gtimu_pkg::*;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [2:0]  trig_sel;
  logic [7:0]  gp_timeout_high;
  logic [7:0]  gp_timeout_low;
  logic [7:0]  main_irq_mask;
  logic [7:0]  timer_field_irq_mask;
  logic [7:0]  error_wakeup_irq_mask;
  logic [15:0] gpt_timeout;
  logic        gpt_start;
  logic        nfc_trigger;
  logic        gpt_expire;
  logic        field_arm;
  logic        read_main;
  logic        read_timer;
  logic        read_error;
  logic [7:2]  main_flags;
  logic [7:0]  timer_flags;
  logic [7:0]  error_flags;
  logic [7:0]  timer_events;
  logic [7:0]  main_irq_status;
  logic        main_active;
  logic        timer_active;
  logic        error_active;
  logic        any_active;
  logic        sd;

  assign sd          = cmd_set_default_in;
  assign gpt_timeout = {gp_timeout_high, gp_timeout_low};

  // ---------------------------------------------------------------------
  // Trigger control and timeout registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      trig_sel <= TRIG_RESET;
    end else if (reg_write_in && reg_addr_in == ADDR_GPT_CTRL) begin
      trig_sel <= reg_wdata_in[TRIG_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      gp_timeout_high <= TIMEOUT_RESET;
      gp_timeout_low  <= TIMEOUT_RESET;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        ADDR_GPT_HIGH: begin
          gp_timeout_high <= reg_wdata_in;
        end
        ADDR_GPT_LOW: begin
          gp_timeout_low <= reg_wdata_in;
        end
        default: begin
          gp_timeout_high <= gp_timeout_high;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Mask registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      main_irq_mask         <= MASK_RESET;
      timer_field_irq_mask  <= MASK_RESET;
      error_wakeup_irq_mask <= MASK_RESET;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        ADDR_MAIN_MASK: begin
          main_irq_mask <= {reg_wdata_in[7:2], 2'h0};
        end
        ADDR_TIMER_MASK: begin
          timer_field_irq_mask <= reg_wdata_in;
        end
        ADDR_ERROR_MASK: begin
          error_wakeup_irq_mask <= reg_wdata_in;
        end
        default: begin
          main_irq_mask <= main_irq_mask;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Trigger source selection
  // ---------------------------------------------------------------------
  assign nfc_trigger = (trig_sel == TRIG_NFC_TX_END) && tx_end_in
                       && nfc_mode_in;

  always_comb begin
    gpt_start = cmd_start_gpt_in;
    case (trig_sel)
      TRIG_NONE: begin
        gpt_start = cmd_start_gpt_in;
      end
      TRIG_RX_END: begin
        gpt_start = cmd_start_gpt_in || rx_end_in;
      end
      TRIG_RX_START: begin
        gpt_start = cmd_start_gpt_in || rx_start_in;
      end
      TRIG_NFC_TX_END: begin
        gpt_start = cmd_start_gpt_in || nfc_trigger;
      end
      default: begin
        gpt_start = cmd_start_gpt_in;
      end
    endcase
  end

  gtimu_gp_timer u_gp_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .abort_in    (sd),
    .start_in    (gpt_start),
    .timeout_in  (gpt_timeout),
    .expire_out  (gpt_expire),
    .running_out (gpt_running_out)
  );

  // ---------------------------------------------------------------------
  // Field switch-off after an NFC transmit-triggered run
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      field_arm <= 1'b0;
    end else if (gpt_start) begin
      field_arm <= nfc_trigger;
    end else if (gpt_expire) begin
      field_arm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      field_off_out <= 1'b0;
    end else begin
      field_off_out <= gpt_expire && field_arm;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt flag banks
  // ---------------------------------------------------------------------
  assign read_main  = reg_read_in && (reg_addr_in == ADDR_MAIN_STATUS);
  assign read_timer = reg_read_in && (reg_addr_in == ADDR_TIMER_STAT);
  assign read_error = reg_read_in && (reg_addr_in == ADDR_ERROR_STAT);

  always_comb begin
    timer_events                = timer_event_in;
    timer_events[TIMER_GPE_BIT] = timer_event_in[TIMER_GPE_BIT]
                                  || gpt_expire;
  end

  gtimu_irq_bank #(.WIDTH(6)) u_main_bank (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .clear_all_in  (sd),
    .read_clear_in (read_main),
    .event_in      (main_event_in),
    .mask_in       (main_irq_mask[7:MAIN_SRC_LSB]),
    .flags_out     (main_flags),
    .active_out    (main_active)
  );

  gtimu_irq_bank #(.WIDTH(8)) u_timer_bank (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .clear_all_in  (sd),
    .read_clear_in (read_timer),
    .event_in      (timer_events),
    .mask_in       (timer_field_irq_mask),
    .flags_out     (timer_flags),
    .active_out    (timer_active)
  );

  gtimu_irq_bank #(.WIDTH(8)) u_error_bank (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .clear_all_in  (sd),
    .read_clear_in (read_error),
    .event_in      (error_event_in),
    .mask_in       (error_wakeup_irq_mask),
    .flags_out     (error_flags),
    .active_out    (error_active)
  );

  assign main_irq_status = {main_flags, |timer_flags, |error_flags};
  assign any_active      = main_active || timer_active || error_active;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= any_active;
    end
  end

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= RDATA_RESET;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_GPT_CTRL: begin
          reg_rdata_out <= {trig_sel, 5'h00};
        end
        ADDR_GPT_HIGH: begin
          reg_rdata_out <= gp_timeout_high;
        end
        ADDR_GPT_LOW: begin
          reg_rdata_out <= gp_timeout_low;
        end
        ADDR_MAIN_MASK: begin
          reg_rdata_out <= main_irq_mask;
        end
        ADDR_TIMER_MASK: begin
          reg_rdata_out <= timer_field_irq_mask;
        end
        ADDR_ERROR_MASK: begin
          reg_rdata_out <= error_wakeup_irq_mask;
        end
        ADDR_MAIN_STATUS: begin
          reg_rdata_out <= main_irq_status;
        end
        ADDR_TIMER_STAT: begin
          reg_rdata_out <= timer_flags;
        end
        ADDR_ERROR_STAT: begin
          reg_rdata_out <= error_flags;
        end
        default: begin
          reg_rdata_out <= RDATA_RESET;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  trig_none_a: assert property (
    (trig_sel == TRIG_NONE && !cmd_start_gpt_in) |-> !gpt_start)
    else $error("timer started without command in no-trigger mode");

  rx_end_start_a: assert property (
    (trig_sel == TRIG_RX_END && rx_end_in && gpt_timeout != 16'h0000
     && !sd) |=> gpt_running_out)
    else $error("end of reception did not start timer");

  field_off_a: assert property (
    (gpt_expire && field_arm && !sd) |=> field_off_out)
    else $error("field not switched off after NFC timer expiry");

  field_cause_a: assert property (
    field_off_out |-> $past(gpt_expire) && $past(field_arm))
    else $error("field switched off without NFC timer expiry");

  unused_code_a: assert property (
    (trig_sel[2] && !cmd_start_gpt_in) |-> !gpt_start)
    else $error("unused trigger code started timer");

  // Cycles since a one-step start, F when idle
  logic [3:0] one_step_age;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sd) begin
      one_step_age <= 4'hF;
    end else if (gpt_start) begin
      one_step_age <= (gpt_timeout == 16'h0001) ? 4'h0 : 4'hF;
    end else if (one_step_age != 4'hF) begin
      one_step_age <= one_step_age + 4'h1;
    end
  end

  one_step_a: assert property (
    (one_step_age == 4'hB && !gpt_start && !sd) |=> gpt_expire)
    else $error("one step timeout did not expire after 12 cycles");

  no_early_a: assert property (
    (gpt_start && gpt_timeout == 16'h0001 && !sd)
    |=> !gpt_expire[*8])
    else $error("timer expired before one step elapsed");

  zero_idle_a: assert property (
    (gpt_start && gpt_timeout == 16'h0000 && !sd) |=> !gpt_running_out)
    else $error("zero timeout started the timer");

  high_write_a: assert property (
    (reg_write_in && reg_addr_in == ADDR_GPT_HIGH && !sd)
    |=> gp_timeout_high == $past(reg_wdata_in))
    else $error("timeout upper byte not written");

  mask_default_a: assert property (
    sd |=> (main_irq_mask == MASK_RESET
            && timer_field_irq_mask == MASK_RESET
            && error_wakeup_irq_mask == MASK_RESET))
    else $error("masks not cleared by set default");

  status_read_a: assert property (
    read_main |=> reg_rdata_out == $past(main_irq_status))
    else $error("main status read returned wrong value");

  main_clear_a: assert property (
    (read_main && main_event_in == 6'h00 && !sd) |=> main_flags == 6'h00)
    else $error("main status not cleared by its read");

  summary_keep_a: assert property (
    (read_main && timer_flags != 8'h00 && !read_timer && !sd)
    |=> main_irq_status[1])
    else $error("timer summary cleared by main status read");

  masked_latch_a: assert property (
    (error_event_in[7] && !sd) |=> error_flags[7])
    else $error("masked or unmasked error flag not latched");

  irq_set_a: assert property (
    any_active |=> irq_out)
    else $error("interrupt output missing for unmasked flag");

  gpe_mask_a: assert property (
    (timer_flags == 8'h20 && timer_field_irq_mask[5]
     && !main_active && !error_active) |=> !irq_out)
    else $error("masked timer expiry raised interrupt");

  irq_clear_a: assert property (
    !any_active |=> !irq_out)
    else $error("interrupt output held without unmasked flag");

  field_off_c: cover property (gpt_start && nfc_trigger ##[1:1000]
                               field_off_out);
  irq_rise_c: cover property (!irq_out ##1 irq_out);
  read_clear_c: cover property (irq_out && read_main ##1 !main_active);

endmodule : gtimu_unit

//--- src/gtimu_pkg.sv
// Package: constants, types and register map of the timer and mask unit
// Function
// - Trigger code 000: timer starts only on the start-timer direct command.
// - Code 001 starts timer at end of reception; code 010 at start.
// - Code 011 starts at NFC end of transmit; expiry switches field off.
// - Timeout counts in steps of eight carrier periods, about 590 ns.
// - Timeout spans one step up to about 38.7 ms.
// - Timeout upper byte lives at 12h, lower byte at 13h, both RW.
// - Main mask at 14h: bits 7..2 mask osc, level, rxs, rxe, txe, col.
// - Timer mask bit 7 masks command done, bit 6 no-response expiry.
// - Timer mask bit 5 masks general purpose timer expiry.
// - Timer mask bits 4 and 3 mask external field on and off.
// - Timer mask bits 2..0 mask collision, guard time, bit rate found.
// - Error mask at 16h bits 7..4 mask CRC, parity, soft, hard framing.
// - Error mask bits 3..0 mask wake timer, amplitude, phase, capacitance.
// - All masks clear to zero at power-up and on Set Default.
// - Read-only main interrupt status sits at 17h.
// - Reading 17h clears bits 7..2; bits 1..0 clear via detail reads.
// - Main bit 1 summarises timer events, bit 0 error events.
package gtimu_pkg;

  // ---------------------------------------------------------------------
  // Register port and map
  // ---------------------------------------------------------------------
  localparam int         ADDR_W           = 6;
  localparam int         DATA_W           = 8;
  localparam logic [5:0] ADDR_GPT_CTRL    = 6'h11;
  localparam logic [5:0] ADDR_GPT_HIGH    = 6'h12;
  localparam logic [5:0] ADDR_GPT_LOW     = 6'h13;
  localparam logic [5:0] ADDR_MAIN_MASK   = 6'h14;
  localparam logic [5:0] ADDR_TIMER_MASK  = 6'h15;
  localparam logic [5:0] ADDR_ERROR_MASK  = 6'h16;
  localparam logic [5:0] ADDR_MAIN_STATUS = 6'h17;
  localparam logic [5:0] ADDR_TIMER_STAT  = 6'h18;
  localparam logic [5:0] ADDR_ERROR_STAT  = 6'h19;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int         TRIG_LSB         = 5;
  localparam int         MAIN_SRC_LSB     = 2;
  localparam int         TIMER_GPE_BIT    = 5;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] TIMEOUT_RESET    = 8'h00;
  localparam logic [2:0] TRIG_RESET       = 3'h0;
  localparam logic [7:0] RDATA_RESET      = 8'h00;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS    = 50;
  localparam int         STEP_NS          = 590;
  localparam int         STEP_CYCLES      =
    (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STEP_LAST        = 4'(STEP_CYCLES - 1);

  typedef enum logic [2:0] {
    TRIG_NONE       = 3'b000,
    TRIG_RX_END     = 3'b001,
    TRIG_RX_START   = 3'b010,
    TRIG_NFC_TX_END = 3'b011
  } gtimu_trig_t;

  typedef enum logic {
    GPT_IDLE = 1'b0,
    GPT_RUN  = 1'b1
  } gtimu_gpt_state_t;

endpackage : gtimu_pkg

//--- src/gtimu_irq_bank.sv
// Sticky interrupt flags of one source group with mask gating
`timescale 1ns/100ps
module gtimu_irq_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             clear_all_in,
  input  wire logic             read_clear_in,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] mask_in,
  output logic      [WIDTH-1:0] flags_out,
  output logic                  active_out
);
  import gtimu_pkg::*;

  // ---------------------------------------------------------------------
  // Flags: a new event wins over a read clear
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || clear_all_in) begin
      flags_out <= '0;
    end else if (read_clear_in) begin
      flags_out <= event_in;
    end else begin
      flags_out <= flags_out | event_in;
    end
  end

  assign active_out = |(flags_out & ~mask_in);

endmodule : gtimu_irq_bank

//--- src/gtimu_gp_timer.sv
// General purpose down counter in steps of eight carrier periods
`timescale 1ns/100ps
module gtimu_gp_timer (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        abort_in,
  input  wire logic        start_in,
  input  wire logic [15:0] timeout_in,
  output logic             expire_out,
  output logic             running_out
);
  import gtimu_pkg::*;

  gtimu_gpt_state_t state;
  logic [3:0]       step_cnt;
  logic [15:0]      remain;
  logic             step_tick;

  assign step_tick   = (state == GPT_RUN) && (step_cnt == STEP_LAST);
  assign running_out = state;

  // ---------------------------------------------------------------------
  // Step divider
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || abort_in || start_in || step_tick) begin
      step_cnt <= 4'h0;
    end else if (state == GPT_RUN) begin
      step_cnt <= step_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Step counter and state
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || abort_in) begin
      state  <= GPT_IDLE;
      remain <= 16'h0000;
    end else if (start_in) begin
      remain <= timeout_in;
      state  <= (timeout_in != 16'h0000) ? GPT_RUN : GPT_IDLE;
    end else if (step_tick) begin
      remain <= remain - 16'h0001;
      case (state)
        GPT_RUN: begin
          if (remain == 16'h0001) begin
            state <= GPT_IDLE;
          end
        end
        default: begin
          state <= GPT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || abort_in || start_in) begin
      expire_out <= 1'b0;
    end else begin
      expire_out <= step_tick && (remain == 16'h0001);
    end
  end

endmodule : gtimu_gp_timer

//--- tb/gtimu_host.sv
// Host model driving the register port on falling edges
`timescale 1ns/100ps
module gtimu_host (
  input  wire logic                         sys_clk_in,
  input  wire logic [gtimu_pkg::DATA_W-1:0] reg_rdata_in,
  output logic      [gtimu_pkg::ADDR_W-1:0] reg_addr_out,
  output logic      [gtimu_pkg::DATA_W-1:0] reg_wdata_out,
  output logic                              reg_write_out,
  output logic                              reg_read_out
);
  import gtimu_pkg::*;

  initial begin
    reg_addr_out  = 6'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out  = 1'b0;
  end

  // Released bus shows the inverse of the last value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_write_out = 1'b1;
    @(negedge sys_clk_in);
    reg_write_out = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_read_out = 1'b1;
    @(negedge sys_clk_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~a;
    d            = reg_rdata_in;
  endtask : rd
endmodule : gtimu_host

//--- tb/testbench.sv
// Self-checking bench for the timer and mask unit
`timescale 1ns/100ps
module testbench;
  import gtimu_pkg::*;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } gtimu_row_t;

  logic       sys_clk_in = 1'b0;
  logic       reset_in   = 1'b1;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       sdef  = 1'b0;
  logic       start = 1'b0;
  logic       rxs   = 1'b0;
  logic       rxe   = 1'b0;
  logic       txe   = 1'b0;
  logic       nfc   = 1'b1;
  logic [7:2] mev   = '0;
  logic [7:0] tev   = '0;
  logic [7:0] eev   = '0;
  logic       irq;
  logic       fo;
  logic       run;
  logic       exp_run;
  int         num_errors = 0;
  int         n_tests    = 0;
  gtimu_row_t rows [8] = '{'{6'h12, 8'hA5, 8'hA5}, '{6'h13, 8'h5A, 8'h5A},
    '{6'h14, 8'hFF, 8'hFC}, '{6'h15, 8'hFF, 8'hFF}, '{6'h16, 8'hFF, 8'hFF},
    '{6'h17, 8'hFF, 8'h00}, '{6'h11, 8'hFF, 8'hE0}, '{6'h3F, 8'hFF, 8'h00}};

  gtimu_unit u_gtimu_unit (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata), .cmd_set_default_in(sdef),
    .cmd_start_gpt_in(start), .rx_start_in(rxs), .rx_end_in(rxe),
    .tx_end_in(txe), .nfc_mode_in(nfc), .main_event_in(mev),
    .timer_event_in(tev), .error_event_in(eev), .irq_out(irq),
    .field_off_out(fo), .gpt_running_out(run));

  gtimu_host u_gtimu_host (.sys_clk_in(sys_clk_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr),
    .reg_read_out(rd));

  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_gtimu_host.rd(a, d);
    check("rdata", d, exp);
  endtask : rdchk

  // 0..2 event groups, 3 rx start, 4 rx end, 5 tx end, 6 start, 7 default
  task automatic strobe(input int which, input logic [7:0] v);
    @(negedge sys_clk_in);
    case (which)
      0: mev = v[7:2];
      1: tev = v;
      2: eev = v;
      3: rxs = 1'b1;
      4: rxe = 1'b1;
      5: txe = 1'b1;
      6: start = 1'b1;
      default: sdef = 1'b1;
    endcase
    @(negedge sys_clk_in);
    {rxs, rxe, txe, start, sdef} = '0;
    {mev, tev, eev} = '0;
  endtask : strobe

  task automatic run_timer(input int exp_n, input logic [7:0] exp_fo);
    int n;
    int f;
    // First running cycle already seen by the start strobe
    n = (run === 1'b1);
    f = 0;
    for (int i = 0; i < 4000 && !(n > 0 && run !== 1'b1); i++) begin
      @(negedge sys_clk_in);
      n += (run === 1'b1);
      f += (fo === 1'b1);
    end
    if (n == 0 || run === 1'b1) begin
      num_errors++;
      end_of_test();
    end
    repeat (3) begin
      @(negedge sys_clk_in);
      f += (fo === 1'b1);
    end
    check("run cycles", 8'(n == exp_n), 8'h01);
    check("field off", 8'(f), exp_fo);
  endtask : run_timer

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    num_errors++;
    end_of_test();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    check("irq reset", 8'(irq), 8'h00);
    for (int i = 0; i < 6; i++) rdchk(rows[i].addr, 8'h00);
    foreach (rows[i]) begin
      u_gtimu_host.wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp);
    end
    strobe(7, 8'h00);
    for (int i = 2; i < 5; i++) rdchk(rows[i].addr, 8'h00);
    // Each mask bit blocks only its own source
    for (int g = 0; g < 3; g++) begin
      for (int b = (g == 0) ? 2 : 0; b < 8; b++) begin
        strobe(7, 8'h00);
        u_gtimu_host.wr(6'(8'h14 + g), ~(8'h01 << b));
        strobe(g, ~(8'h01 << b));
        repeat (2) @(negedge sys_clk_in);
        check("irq masked", 8'(irq), 8'h00);
        strobe(g, 8'h01 << b);
        repeat (2) @(negedge sys_clk_in);
        check("irq open", 8'(irq), 8'h01);
      end
    end
    strobe(7, 8'h00);
    for (int g = 0; g < 3; g++) u_gtimu_host.wr(6'(8'h14 + g), 8'hFF);
    for (int g = 0; g < 3; g++) strobe(g, 8'hFF);
    repeat (2) @(negedge sys_clk_in);
    check("irq all masked", 8'(irq), 8'h00);
    rdchk(6'h17, 8'hFF);
    rdchk(6'h17, 8'h03);
    rdchk(6'h18, 8'hFF);
    rdchk(6'h17, 8'h01);
    rdchk(6'h19, 8'hFF);
    rdchk(6'h17, 8'h00);
    // Every trigger code against every source
    for (int c = 0; c < 8; c++) begin
      for (int s = 3; s < 6; s++) begin
        strobe(7, 8'h00);
        u_gtimu_host.wr(6'h13, 8'h10);
        u_gtimu_host.wr(6'h11, 8'(c << 5));
        strobe(s, 8'h00);
        @(negedge sys_clk_in);
        exp_run = (c == 1 && s == 4) || (c == 2 && s == 3) ||
                  (c == 3 && s == 5);
        check("trigger", 8'(run), 8'(exp_run));
      end
    end
    nfc = 1'b0;
    strobe(7, 8'h00);
    u_gtimu_host.wr(6'h13, 8'h10);
    u_gtimu_host.wr(6'h11, 8'h60);
    strobe(5, 8'h00);
    @(negedge sys_clk_in);
    check("tx end outside nfc", 8'(run), 8'h00);
    nfc = 1'b1;
    strobe(7, 8'h00);
    u_gtimu_host.wr(6'h12, 8'h01);
    u_gtimu_host.wr(6'h13, 8'h01);
    strobe(6, 8'h00);
    run_timer(257 * STEP_CYCLES, 8'h00);
    rdchk(6'h18, 8'h20);
    strobe(7, 8'h00);
    u_gtimu_host.wr(6'h13, 8'h01);
    u_gtimu_host.wr(6'h11, 8'h60);
    strobe(5, 8'h00);
    run_timer(STEP_CYCLES, 8'h01);
    check("irq gp expiry", 8'(irq), 8'h01);
    rdchk(6'h17, 8'h02);
    end_of_test();
  end
endmodule : testbench
